// ---- hdl/pcs_pkg.sv ----
package pcs_pkg;

   // Register word addresses on the plain register port.
   localparam logic [7:0] REG_VSET_HI = 8'h01;
   localparam logic [7:0] REG_ISET_HI = 8'h03;
   localparam logic [7:0] REG_PSET_HI = 8'h05;
   localparam logic [7:0] REG_ZALPHA_HI = 8'h19;
   localparam logic [7:0] REG_QUERY = 8'h1c;
   localparam logic [7:0] REG_EXPECTED = 8'h1d;
   localparam logic [7:0] REG_VSLEW_HI = 8'h1f;
   localparam logic [7:0] REG_ISLEW_HI = 8'h21;
   localparam logic [7:0] REG_MALPHA_HI = 8'h23;
   localparam logic [7:0] REG_VLIMIT_HI = 8'h2b;
   localparam logic [7:0] REG_ILIMIT_HI = 8'h2d;
   localparam logic [7:0] REG_PROC_CFG = 8'h2f;
   localparam logic [7:0] REG_CONTROL = 8'h30;
   localparam logic [7:0] REG_STATUS = 8'h31;
   localparam logic [7:0] REG_COEF_FIRST = 8'h33;
   localparam logic [7:0] REG_COEF_LAST = 8'h3c;
   localparam logic [7:0] REG_RESULT_HI = 8'h3d;
   localparam logic [7:0] REG_RESULT_LO = 8'h3e;
   localparam logic [7:0] REG_FILT_FIRST = 8'h40;
   localparam logic [7:0] REG_LIST_FIRST = 8'h64;
   localparam logic [7:0] REG_LIST_LAST = 8'h83;

   // Field positions.
   localparam int CFG_SRC_ANALOG = 0;
   localparam int CFG_OUT_CURRENT = 1;
   localparam int CFG_LIMIT_EN = 2;
   localparam int CFG_PROC_EN = 3;
   localparam int CTRL_ANALOG_MODE = 0;
   localparam int CTRL_EXPECT_EN = 1;
   localparam int STAT_CMD_ERROR = 0;

   // Fixed-point scales: setpoints IQ15, filter alphas IQ24.
   localparam int Q_SP = 15;
   localparam int Q_ALPHA = 24;
   localparam logic [31:0] SP_ONE = 32'h0000_8000;
   localparam logic [31:0] ALPHA_ONE = 32'h0100_0000;
   localparam logic [7:0] QUERY_CMD_MAX = 8'h05;

   // Timing.
   localparam int CLK_HZ = 125_000_000;
   localparam int SAMPLE_HZ = 125;
   localparam int SLEW_PERIOD_US = 1000;
   localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;
   localparam int MS_CYCLES = CLK_HZ / 1_000_000 * SLEW_PERIOD_US;

   typedef struct packed {
      logic [7:0] mod_addr;
      logic [7:0] cmd;
   } mod_query_t;

   typedef struct packed {
      logic [15:0] vprog;
      logic [15:0] iprog;
      logic [15:0] pprog;
   } analog_in_t;

   typedef enum logic [1:0] {Q_IDLE, Q_REQ, Q_WAIT} query_state_t;

endpackage

// ---- hdl/process_control_supervisor.sv ----
module process_control_supervisor import pcs_pkg::*; #(
   parameter int SAMPLE_DIV = SAMPLE_CYCLES,
   parameter int MS_DIV = MS_CYCLES,
   parameter int MAX_MODULES = 32
) (
   // Clock, reset and enable.
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [15:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rd_data_o,
   // Digitised analog programming inputs and raw monitors.
   input wire analog_in_t analog_i,
   input wire logic [31:0] mon_v_i,
   input wire logic [31:0] mon_i_i,
   input wire logic [31:0] mon_p_i,
   input wire logic [31:0] imp_i,
   // Switch pins for the expected module count.
   input wire logic expect_switch_i,
   input wire logic [5:0] expect_switch_count_i,
   // Module discovery.
   input wire logic disc_clear_i,
   input wire logic disc_valid_i,
   input wire logic [7:0] disc_addr_i,
   // Module bus query.
   output logic mbus_req_o,
   output mod_query_t mbus_query_o,
   input wire logic mbus_resp_valid_i,
   input wire logic [31:0] mbus_resp_data_i,
   // Setpoint commands, analog monitor outputs and faults.
   output logic [31:0] v_cmd_o,
   output logic [31:0] i_cmd_o,
   output logic [31:0] v_aout_o,
   output logic [31:0] i_aout_o,
   output logic command_error_o,
   output logic too_few_o,
   output logic count_mismatch_o
);

   // Refuse tick dividers too short to count and list sizes the index widths cannot serve.
   if (SAMPLE_DIV < 2 || MS_DIV < 2 || MAX_MODULES != 32) begin : g_bad_params
      $error("process_control_supervisor: unsupported parameters");
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   logic [15:0] wreg [0:63];
   logic [7:0] mod_list [0:MAX_MODULES-1];
   logic [5:0] mod_count;
   logic [31:0] query_result;
   query_state_t qstate;
   logic [31:0] filt [0:3];
   logic [31:0] slew_cmd [0:1];
   logic [31:0] e1, e2, y1, y2, comp_out;
   logic [31:0] sample_cnt, ms_cnt;
   logic sample_tick, ms_tick;
   logic sw_meta, sw_sync;
   logic [5:0] swc_meta, swc_sync;

   // Reads a HI/LO word pair as one 32-bit value.
   function automatic logic [31:0] pair(input logic [7:0] a);
      logic [5:0] i;
      i = a[5:0];
      return {wreg[i], wreg[i + 6'h01]};
   endfunction

   // Tells which word addresses hold write registers.
   function automatic logic writable(input logic [7:0] a);
      logic ok;
      ok = 1'b0;
      if (a >= REG_VSET_HI && a <= REG_PSET_HI + 8'h01) begin
         ok = 1'b1;
      end else if (a == REG_ZALPHA_HI || a == REG_ZALPHA_HI + 8'h01) begin
         ok = 1'b1;
      end else if (a == REG_QUERY || a == REG_EXPECTED) begin
         ok = 1'b1;
      end else if (a >= REG_VSLEW_HI && a <= REG_MALPHA_HI + 8'h01) begin
         ok = 1'b1;
      end else if (a >= REG_VLIMIT_HI && a <= REG_CONTROL) begin
         ok = 1'b1;
      end else if (a >= REG_COEF_FIRST && a <= REG_COEF_LAST) begin
         ok = 1'b1;
      end
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   // Switch pins pass two flip-flops before use.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sw_meta <= 1'b0;
         sw_sync <= 1'b0;
         swc_meta <= 6'h00;
         swc_sync <= 6'h00;
      end else if (ce_i) begin
         sw_meta <= expect_switch_i;
         sw_sync <= sw_meta;
         swc_meta <= expect_switch_count_i;
         swc_sync <= swc_meta;
      end
   end

   // Sample and millisecond ticks.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sample_cnt <= 32'h0;
         ms_cnt <= 32'h0;
         sample_tick <= 1'b0;
         ms_tick <= 1'b0;
      end else if (ce_i) begin
         sample_tick <= (sample_cnt == 32'(SAMPLE_DIV - 1));
         ms_tick <= (ms_cnt == 32'(MS_DIV - 1));
         sample_cnt <= (sample_cnt == 32'(SAMPLE_DIV - 1)) ? 32'h0 : sample_cnt + 32'h1;
         ms_cnt <= (ms_cnt == 32'(MS_DIV - 1)) ? 32'h0 : ms_cnt + 32'h1;
      end
   end

   // Write registers; every limit and coefficient resets to zero.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         for (int k = 0; k < 64; k++) begin
            wreg[k] <= 16'h0000;
         end
      end else if (ce_i && wr_i && writable(addr_i)) begin
         wreg[addr_i[5:0]] <= wr_data_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Decoded fields and derived scales.
   logic [15:0] cfg, ctrl, exp_word;
   logic [31:0] vset, iset, pset, vlimit, ilimit, vfs, ifs, vprog_s, iprog_s;
   logic [5:0] exp_n, scale_n;
   logic check_en, analog_mode;
   assign cfg = wreg[REG_PROC_CFG[5:0]];
   assign ctrl = wreg[REG_CONTROL[5:0]];
   assign exp_word = wreg[REG_EXPECTED[5:0]];
   assign vset = pair(REG_VSET_HI);
   assign iset = pair(REG_ISET_HI);
   assign pset = pair(REG_PSET_HI);
   assign vlimit = pair(REG_VLIMIT_HI);
   assign ilimit = pair(REG_ILIMIT_HI);
   assign analog_mode = ctrl[CTRL_ANALOG_MODE];
   assign check_en = (exp_word != 16'h0) || sw_sync || ctrl[CTRL_EXPECT_EN];
   assign exp_n = (exp_word != 16'h0) ? exp_word[5:0] : swc_sync;
   // The current scale follows the expected or the discovered count.
   assign scale_n = check_en ? exp_n : mod_count;
   assign vfs = (vlimit != 32'h0) ? vlimit : SP_ONE;
   assign ifs = (ilimit != 32'h0) ? ilimit :
                ((scale_n == 6'h0) ? SP_ONE : 32'(scale_n) * SP_ONE);
   assign vprog_s = 32'((64'(analog_i.vprog) * 64'(vfs)) >> Q_SP);
   assign iprog_s = 32'((64'(analog_i.iprog) * 64'(ifs)) >> Q_SP);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Compensator: y = b0 e + b1 e1 + b2 e2 - a1 y1 - a2 y2, all IQ15.
   logic [31:0] proc_sp, proc_fb, err;
   logic signed [63:0] acc;
   logic [31:0] next_y;
   assign proc_sp = cfg[CFG_SRC_ANALOG] ? 32'(analog_i.vprog) : pset;
   assign proc_fb = 32'(analog_i.pprog);
   assign err = proc_sp - proc_fb;
   always_comb begin
      acc = $signed(pair(REG_COEF_FIRST)) * $signed(err)
          + $signed(pair(REG_COEF_FIRST + 8'h02)) * $signed(e1)
          + $signed(pair(REG_COEF_FIRST + 8'h04)) * $signed(e2)
          - $signed(pair(REG_COEF_FIRST + 8'h06)) * $signed(y1)
          - $signed(pair(REG_COEF_FIRST + 8'h08)) * $signed(y2);
      acc = acc >>> Q_SP;
      if (acc < 64'sd0) begin
         next_y = 32'h0;
      end else if (acc > $signed(64'(SP_ONE))) begin
         next_y = SP_ONE;
      end else begin
         next_y = acc[31:0];
      end
      if (cfg[CFG_LIMIT_EN] && analog_mode && next_y > 32'(analog_i.iprog)) begin
         next_y = 32'(analog_i.iprog);
      end
   end

   // Compensator history, advanced once per sample.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         e1 <= 32'h0;
         e2 <= 32'h0;
         y1 <= 32'h0;
         y2 <= 32'h0;
         comp_out <= 32'h0;
      end else if (ce_i && sample_tick) begin
         e1 <= err;
         e2 <= e1;
         y1 <= next_y;
         y2 <= y1;
         comp_out <= next_y;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Setpoint targets: analog, saturated digital, or process output.
   logic [31:0] target [0:1];
   logic [31:0] comp_scaled [0:1];
   assign comp_scaled[0] = 32'((64'(comp_out) * 64'(vfs)) >> Q_SP);
   assign comp_scaled[1] = 32'((64'(comp_out) * 64'(ifs)) >> Q_SP);
   always_comb begin
      if (analog_mode) begin
         target[0] = vprog_s;
         target[1] = iprog_s;
      end else begin
         target[0] = (vset > vfs) ? vfs : vset;
         target[1] = (iset > ifs) ? ifs : iset;
      end
      if (cfg[CFG_PROC_EN]) begin
         if (cfg[CFG_OUT_CURRENT]) begin
            target[1] = comp_scaled[1];
         end else begin
            target[0] = comp_scaled[0];
         end
      end
   end

   // Slew limit per millisecond; a zero rate lets the command jump.
   logic [31:0] rate [0:1];
   assign rate[0] = pair(REG_VSLEW_HI);
   assign rate[1] = pair(REG_ISLEW_HI);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         slew_cmd[0] <= 32'h0;
         slew_cmd[1] <= 32'h0;
      end else if (ce_i) begin
         for (int c = 0; c < 2; c++) begin
            if (rate[c] == 32'h0) begin
               slew_cmd[c] <= target[c];
            end else if (ms_tick) begin
               if (target[c] > slew_cmd[c]) begin
                  slew_cmd[c] <= (target[c] - slew_cmd[c] > rate[c]) ?
                                 slew_cmd[c] + rate[c] : target[c];
               end else begin
                  slew_cmd[c] <= (slew_cmd[c] - target[c] > rate[c]) ?
                                 slew_cmd[c] - rate[c] : target[c];
               end
            end
         end
      end
   end
   assign v_cmd_o = slew_cmd[0];
   assign i_cmd_o = slew_cmd[1];

   ////////////////////////////////////////////////////////////////////////////////////////
   // Single-pole filters: y = a y + (1 - a) x, monitors and impedance.
   logic [31:0] raw [0:3];
   assign raw[0] = mon_v_i;
   assign raw[1] = mon_i_i;
   assign raw[2] = mon_p_i;
   assign raw[3] = imp_i;
   generate
      for (genvar g = 0; g < 4; g++) begin : g_filt
         logic [31:0] alpha;
         assign alpha = (g == 3) ? pair(REG_ZALPHA_HI) : pair(REG_MALPHA_HI);
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               filt[g] <= 32'h0;
            end else if (ce_i && sample_tick) begin
               filt[g] <= 32'((64'(alpha) * 64'(filt[g])
                        + 64'(ALPHA_ONE - alpha) * 64'(raw[g])) >> Q_ALPHA);
            end
         end
      end
   endgenerate

   // Analog monitor outputs in the span set by the limits, or by the default scales where a limit is zero.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         v_aout_o <= 32'h0;
         i_aout_o <= 32'h0;
      end else if (ce_i) begin
         v_aout_o <= 32'((64'(filt[0]) << Q_SP) / 64'(vfs));
         i_aout_o <= 32'((64'(filt[1]) << Q_SP) / 64'(ifs));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Discovered list kept sorted by insertion; duplicates are ignored.
   logic [MAX_MODULES-1:0] below, dup;
   generate
      for (genvar s = 0; s < MAX_MODULES; s++) begin : g_list
         assign below[s] = (6'(s) < mod_count) && (mod_list[s] < disc_addr_i);
         assign dup[s] = (6'(s) < mod_count) && (mod_list[s] == disc_addr_i);
         always_ff @(posedge clk_i) begin
            if (reset_i || (ce_i && disc_clear_i)) begin
               mod_list[s] <= 8'h00;
            end else if (ce_i && disc_valid_i && dup == '0 && mod_count != 6'(MAX_MODULES)) begin
               if (!below[s]) begin
                  if (s == 0 || below[(s == 0) ? 0 : s - 1]) begin
                     mod_list[s] <= disc_addr_i;
                  end else begin
                     mod_list[s] <= mod_list[(s == 0) ? 0 : s - 1];
                  end
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (reset_i || (ce_i && disc_clear_i)) begin
         mod_count <= 6'h00;
      end else if (ce_i && disc_valid_i && dup == '0 && mod_count != 6'(MAX_MODULES)) begin
         mod_count <= mod_count + 6'h01;
      end
   end

   // Faults: module count checks follow the count; command error is sticky.
   logic qwrite;
   assign qwrite = ce_i && wr_i && addr_i == REG_QUERY;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         too_few_o <= 1'b0;
         count_mismatch_o <= 1'b0;
         command_error_o <= 1'b0;
      end else if (ce_i) begin
         too_few_o <= check_en && (mod_count < exp_n);
         count_mismatch_o <= (exp_word != 16'h0) && (mod_count != exp_word[5:0]);
         if (vlimit > SP_ONE && !analog_mode && vset > SP_ONE) begin
            command_error_o <= 1'b1;
         end else if (wr_i && addr_i == REG_STATUS && wr_data_i[STAT_CMD_ERROR]) begin
            command_error_o <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Module query: a one-cycle request, then wait until the module answers.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         qstate <= Q_IDLE;
         mbus_req_o <= 1'b0;
         mbus_query_o <= '0;
         query_result <= 32'h0;
      end else if (ce_i) begin
         case (qstate)
            Q_IDLE: begin
               if (qwrite && wr_data_i[7:0] <= QUERY_CMD_MAX) begin
                  mbus_query_o <= mod_query_t'(wr_data_i);
                  mbus_req_o <= 1'b1;
                  qstate <= Q_REQ;
               end
            end
            Q_REQ: begin
               mbus_req_o <= 1'b0;
               qstate <= Q_WAIT;
            end
            Q_WAIT: begin
               if (mbus_resp_valid_i) begin
                  query_result <= mbus_resp_data_i;
                  qstate <= Q_IDLE;
               end
            end
            default: qstate <= Q_IDLE;
         endcase
      end
   end

   // Read data stand only in the cycle after the strobe.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_data_o <= 16'h0;
      end else if (ce_i) begin
         rd_data_o <= 16'h0;
         if (rd_i) begin
            if (addr_i == REG_RESULT_HI) begin
               rd_data_o <= query_result[31:16];
            end else if (addr_i == REG_RESULT_LO) begin
               rd_data_o <= query_result[15:0];
            end else if (addr_i == REG_STATUS) begin
               rd_data_o <= {4'h0, mod_count, (qstate != Q_IDLE), count_mismatch_o,
                             too_few_o, check_en, 1'b0, command_error_o};
            end else if (addr_i >= REG_FILT_FIRST && addr_i < REG_FILT_FIRST + 8'h08) begin
               rd_data_o <= addr_i[0] ? filt[addr_i[2:1]][15:0] : filt[addr_i[2:1]][31:16];
            end else if (addr_i >= REG_LIST_FIRST && addr_i <= REG_LIST_LAST) begin
               rd_data_o <= {8'h00, mod_list[5'(addr_i - REG_LIST_FIRST)]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   logic sorted_ok;
   always_comb begin
      sorted_ok = 1'b1;
      for (int k = 1; k < MAX_MODULES; k++) begin
         if (6'(k) < mod_count && mod_list[k] <= mod_list[k - 1]) begin
            sorted_ok = 1'b0;
         end
      end
   end

   sequence s_query_write;
      qstate == Q_IDLE && qwrite && wr_data_i[7:0] <= QUERY_CMD_MAX;
   endsequence
   sequence s_query_issue;
      ##1 mbus_req_o ##1 (!mbus_req_o && qstate == Q_WAIT);
   endsequence

   chk_query_issue: assert property (@(posedge clk_i) disable iff (reset_i)
      s_query_write |-> s_query_issue) else $error("query not issued");
   chk_bad_cmd: assert property (@(posedge clk_i) disable iff (reset_i)
      qstate == Q_IDLE && qwrite && wr_data_i[7:0] > QUERY_CMD_MAX |=> !mbus_req_o)
      else $error("bad command issued");
   chk_result_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !(qstate == Q_WAIT && mbus_resp_valid_i && ce_i) |=> $stable(query_result))
      else $error("query result changed");
   chk_list_sorted: assert property (@(posedge clk_i) disable iff (reset_i)
      sorted_ok) else $error("module list not ascending");
   chk_dig_saturate: assert property (@(posedge clk_i) disable iff (reset_i)
      !analog_mode && !cfg[CFG_PROC_EN] |-> target[0] <= vfs && target[1] <= ifs)
      else $error("digital setpoint not saturated");
   chk_slew_step: assert property (@(posedge clk_i) disable iff (reset_i)
      ce_i && !ms_tick && rate[0] != 32'h0 |=> $stable(v_cmd_o))
      else $error("voltage command moved off the millisecond tick");
   chk_cmd_error: assert property (@(posedge clk_i) disable iff (reset_i)
      ce_i && vlimit > SP_ONE && !analog_mode && vset > SP_ONE |=> command_error_o)
      else $error("command error missed");
   chk_too_few: assert property (@(posedge clk_i) disable iff (reset_i)
      ce_i && check_en && mod_count < exp_n |=> too_few_o) else $error("too few missed");
   chk_proc_clamp: assert property (@(posedge clk_i) disable iff (reset_i)
      ce_i && sample_tick && cfg[CFG_LIMIT_EN] && analog_mode
      |=> comp_out <= 32'($past(analog_i.iprog))) else $error("process output not clamped");
   chk_filter_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      !sample_tick |=> $stable(filt[0]) && $stable(filt[3]))
      else $error("filter moved between samples");

endmodule

// ---- tb/module_bus_model.sv ----
module module_bus_model import pcs_pkg::*; #(
   parameter int DELAY = 20
) (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_i,
   // Query from the supervisor, answer back to it.
   input wire logic req_i,
   input wire mod_query_t query_i,
   output logic resp_valid_o,
   output logic [31:0] resp_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int count;
   mod_query_t held;

   // Answers each request after a fixed delay; idle data toggles so stale values never match.
   always @(posedge clk_i) begin
      if (reset_i) begin
         count <= 0;
         resp_valid_o <= 1'b0;
         resp_data_o <= 32'h0;
      end else begin
         resp_valid_o <= (count == 1);
         if (count == 1) begin
            resp_data_o <= {8'h00, held.mod_addr, 8'ha5, held.cmd};
         end else begin
            resp_data_o <= ~resp_data_o;
         end
         if (req_i) begin
            held <= query_i;
            count <= DELAY;
         end else if (count > 0) begin
            count <= count - 1;
         end
      end
   end
endmodule

// ---- tb/process_control_supervisor_tb_top.sv ----
module process_control_supervisor_tb_top import pcs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0, disc_clear_i = 0, disc_valid_i = 0;
   logic ce_i = 1, expect_switch_i = 0;
   logic [5:0] expect_switch_count_i = 6'h00;
   logic [31:0] mon_v_i = 32'h0000_4000, mon_i_i = 32'h0000_2000, mon_p_i = 32'h0000_1000;
   logic [31:0] imp_i = 32'h0000_0800;
   logic [7:0] addr_i = 8'h00, disc_addr_i = 8'h00;
   logic [15:0] wr_data_i = 16'h0000, rd_data_o;
   logic [31:0] v_cmd_o, i_cmd_o, v_aout_o, i_aout_o, resp_data, prev;
   logic mbus_req_o, resp_valid, command_error_o, too_few_o, count_mismatch_o, step_bad;
   mod_query_t mbus_query_o;
   analog_in_t analog_i = '{16'h2000, 16'h4000, 16'h1000};
   int n_mismatch = 0, compares = 0;

   // Clock, design and module bus partner.
   always #4 clk_i = ~clk_i;
   process_control_supervisor #(.SAMPLE_DIV(50), .MS_DIV(10)) process_control_supervisor_inst (
      .clk_i(clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
      .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .analog_i(analog_i),
      .mon_v_i(mon_v_i), .mon_i_i(mon_i_i), .mon_p_i(mon_p_i), .imp_i(imp_i),
      .expect_switch_i(expect_switch_i), .expect_switch_count_i(expect_switch_count_i),
      .disc_clear_i(disc_clear_i), .disc_valid_i(disc_valid_i), .disc_addr_i(disc_addr_i),
      .mbus_req_o(mbus_req_o), .mbus_query_o(mbus_query_o), .mbus_resp_valid_i(resp_valid),
      .mbus_resp_data_i(resp_data), .v_cmd_o(v_cmd_o), .i_cmd_o(i_cmd_o),
      .v_aout_o(v_aout_o), .i_aout_o(i_aout_o), .command_error_o(command_error_o),
      .too_few_o(too_few_o), .count_mismatch_o(count_mismatch_o));
   module_bus_model #(.DELAY(20)) module_bus_model_inst (.clk_i(clk_i), .reset_i(reset_i),
      .req_i(mbus_req_o), .query_i(mbus_query_o), .resp_valid_o(resp_valid),
      .resp_data_o(resp_data));

   ////////////////////////////////////////////////////////////////////////////////
   // Comparison, register access and closing tasks.
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wr_data_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic wr32(input logic [7:0] a, input logic [31:0] d);
      wr(a, d[31:16]);
      wr(a + 8'h01, d[15:0]);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      chk(name, {16'h0000, exp}, {16'h0000, rd_data_o});
   endtask
   task automatic query(input logic [7:0] ma, input logic [7:0] cmd);
      int k;
      wr(REG_QUERY, {ma, cmd});
      @(negedge clk_i);
      chk("query request", 32'h1, {31'h0, mbus_req_o});
      chk("query word", {16'h0000, ma, cmd}, {16'h0000, mbus_query_o});
      for (k = 0; k < 100 && !resp_valid; k++) @(negedge clk_i);
      chk("query answer", 32'h1, {31'h0, resp_valid});
      repeat (3) @(posedge clk_i);
      rd(REG_RESULT_HI, {8'h00, ma}, "result high");
      rd(REG_RESULT_LO, {8'ha5, cmd}, "result low");
   endtask
   task automatic tally_and_finish;
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic discover(input logic [7:0] a);
      @(posedge clk_i);
      disc_valid_i <= 1'b1;
      disc_addr_i <= a;
      @(posedge clk_i);
      disc_valid_i <= 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung handshake.
   initial begin
      #200000;
      n_mismatch++;
      tally_and_finish();
   end

   // Main test sequence.
   initial begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(REG_STATUS, 16'h0000, "status after reset");
      rd(8'hff, 16'h0000, "unmapped read");
      rd(REG_VLIMIT_HI, 16'h0000, "voltage limit reset");
      for (int c = 0; c < 6; c++) query(8'h10 + 8'(c), 8'(c));
      wr(REG_QUERY, 16'h1106);
      @(negedge clk_i);
      chk("refused request", 32'h0, {31'h0, mbus_req_o});
      repeat (30) @(posedge clk_i);
      rd(REG_RESULT_LO, 16'ha505, "result held");
      // With zero alphas the filters pass the monitors through unchanged.
      rd(REG_FILT_FIRST + 8'h01, 16'h4000, "voltage readback");
      rd(REG_FILT_FIRST + 8'h07, 16'h0800, "impedance readback");
      chk("voltage monitor out", 32'h0000_4000, v_aout_o);
      chk("current monitor out", 32'h0000_2000, i_aout_o);
      discover(8'h30);
      discover(8'h10);
      discover(8'h20);
      rd(REG_LIST_FIRST, 16'h0010, "list entry 0");
      rd(REG_LIST_FIRST + 8'h01, 16'h0020, "list entry 1");
      rd(REG_LIST_FIRST + 8'h02, 16'h0030, "list entry 2");
      chk("scale from discovered", 32'h0000_0aaa, i_aout_o);
      // Switch pins ask for four modules while three are present.
      @(posedge clk_i);
      expect_switch_i <= 1'b1;
      expect_switch_count_i <= 6'h04;
      repeat (8) @(negedge clk_i);
      chk("switch too few", 32'h1, {31'h0, too_few_o});
      chk("scale from expected", 32'h0000_0800, i_aout_o);
      wr(REG_CONTROL, 16'h0002);
      wr(REG_EXPECTED, 16'h0005);
      repeat (8) @(negedge clk_i);
      chk("too few", 32'h1, {31'h0, too_few_o});
      chk("count mismatch", 32'h1, {31'h0, count_mismatch_o});
      wr(REG_EXPECTED, 16'h0003);
      repeat (8) @(negedge clk_i);
      chk("count match", 32'h0, {31'h0, count_mismatch_o});
      // A write while the clock enable is low must not land.
      @(posedge clk_i);
      ce_i <= 1'b0;
      wr(REG_EXPECTED, 16'h0005);
      ce_i <= 1'b1;
      repeat (8) @(negedge clk_i);
      chk("write while frozen", 32'h0, {31'h0, count_mismatch_o});
      wr32(REG_VLIMIT_HI, 32'h0000_4000);
      wr32(REG_VSET_HI, 32'h0000_8000);
      repeat (40) @(negedge clk_i);
      chk("saturated setpoint", 32'h0000_4000, v_cmd_o);
      chk("scaled monitor out", 32'h0000_8000, v_aout_o);
      wr32(REG_VSLEW_HI, 32'h0000_1000);
      wr32(REG_VSET_HI, 32'h0000_2000);
      step_bad = 1'b0;
      prev = v_cmd_o;
      for (int i = 0; i < 60; i++) begin
         @(negedge clk_i);
         if (prev - v_cmd_o > 32'h0000_1000) step_bad = 1'b1;
         prev = v_cmd_o;
      end
      chk("slew step", 32'h0, {31'h0, step_bad});
      chk("slewed setpoint", 32'h0000_2000, v_cmd_o);
      wr32(REG_VLIMIT_HI, 32'h0001_0000);
      wr32(REG_VSET_HI, 32'h0000_c000);
      repeat (8) @(negedge clk_i);
      chk("command error", 32'h1, {31'h0, command_error_o});
      wr32(REG_VSET_HI, 32'h0000_4000);
      wr(REG_STATUS, 16'h0001);
      repeat (4) @(negedge clk_i);
      chk("command error cleared", 32'h0, {31'h0, command_error_o});
      // Process loop with b0 = 1.0 drives the current over a three-module span.
      wr32(REG_COEF_FIRST, 32'h0000_8000);
      wr32(REG_PSET_HI, 32'h0000_3000);
      wr(REG_PROC_CFG, 16'h000a);
      repeat (60) @(negedge clk_i);
      chk("process current command", 32'h0000_6000, i_cmd_o);
      wr(REG_PROC_CFG, 16'h000b);
      repeat (60) @(negedge clk_i);
      chk("analog process setpoint", 32'h0000_3000, i_cmd_o);
      @(posedge clk_i);
      analog_i.iprog <= 16'h0800;
      wr(REG_PROC_CFG, 16'h000f);
      wr(REG_CONTROL, 16'h0003);
      repeat (60) @(negedge clk_i);
      chk("clamped process command", 32'h0000_1800, i_cmd_o);
      // A readback alpha of 1.0 freezes the monitors while impedance still follows.
      wr32(REG_MALPHA_HI, ALPHA_ONE);
      mon_v_i <= 32'h0000_1000;
      imp_i <= 32'h0000_0400;
      repeat (120) @(posedge clk_i);
      rd(REG_FILT_FIRST + 8'h01, 16'h4000, "held voltage readback");
      rd(REG_FILT_FIRST + 8'h07, 16'h0400, "impedance follows");
      @(posedge clk_i);
      disc_clear_i <= 1'b1;
      @(posedge clk_i);
      disc_clear_i <= 1'b0;
      rd(REG_LIST_FIRST, 16'h0000, "list cleared");
      tally_and_finish();
   end
endmodule
